/* verilog/csc_synth_ctrl.sv */
// clock synthesizer control: apb registers, vco lock model, power-on count, clock loss
// assumes reference clock and mode strap arrive asynchronously on pins
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "csc_cfg.svh"

module csc_synth_ctrl
   import csc_pkg::*;
#(
   parameter int POR_PERIODS = `CSC_POR_PERIODS,
   parameter int LOCK_PERIODS = `CSC_LOCK_PERIODS,
   parameter int LOSS_CYCLES = `CSC_LOSS_CYCLES
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic ref_clk_pin,
   input wire logic vco_mode_strap,
   // synthesizer results
   output csc_freq_t freq_q,
   output logic vco_locked,
   output logic sys_reset_n
);

   function automatic logic [10:0] vco_of(input csc_ctrl_t c);
      vco_of = ({5'h00, c.mult} + 11'h001) << (c.prescale ? 4 : 2);
   endfunction

   function automatic logic [13:0] out_of(input csc_ctrl_t c);
      out_of = {3'h0, vco_of(c)} << ({1'b0, c.range, 1'b0} + {2'b00, c.postdiv});
   endfunction

   localparam csc_ctrl_t CTRL_RST = '{mult: `CSC_RST_MULT, range: `CSC_RST_RANGE,
      postdiv: `CSC_RST_POSTDIV, prescale: `CSC_RST_PRESCALE};

   csc_ctrl_t ctrl_q;
   csc_state_t state_q;
   logic [2:0] ref_sync_q;
   logic [1:0] strap_sync_q;
   logic [1:0] cap_cnt_q;
   logic use_vco_q;
   logic [15:0] lock_cnt_q;
   logic [15:0] por_cnt_q;
   logic [31:0] loss_cnt_q;
   logic overshoot_q;
   logic ref_edge;
   logic lost_now;
   logic soft_rst;
   logic wr_ctrl;
   logic vco_change;
   logic raise;
   csc_ctrl_t wr_val;
   csc_status_t status;

   // synchronisers: first stage feeds only the second
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ref_sync_q <= 3'h0;
         strap_sync_q <= 2'h0;
      end else if (clk_en) begin
         ref_sync_q <= {ref_sync_q[1:0], ref_clk_pin};
         strap_sync_q <= {strap_sync_q[0], vco_mode_strap};
      end
   end

   assign ref_edge = ref_sync_q[1] & ~ref_sync_q[2];

   // strap is taken once the synchroniser has filled after release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cap_cnt_q <= 2'h0;
         use_vco_q <= 1'b1;
      end else if (clk_en && cap_cnt_q != 2'h3) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
         if (cap_cnt_q == 2'h2) begin
            use_vco_q <= strap_sync_q[1];
         end
      end
   end

   // reference watchdog
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loss_cnt_q <= 32'h0;
      end else if (clk_en) begin
         if (ref_edge) begin
            loss_cnt_q <= 32'h0;
         end else if (!lost_now) begin
            loss_cnt_q <= loss_cnt_q + 32'h1;
         end
      end
   end

   assign lost_now = loss_cnt_q >= 32'(LOSS_CYCLES - 1);
   // a lost clock resets control, lock count and overshoot; the captured strap is kept
   assign soft_rst = (state_q == CSC_ST_LOST);

   // apb: zero wait states, unmapped offsets answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable &&
      (paddr != `CSC_OFS_CTRL) && (paddr != `CSC_OFS_STATUS);
   assign wr_ctrl = psel && penable && pwrite && (paddr == `CSC_OFS_CTRL);

   always_comb begin
      wr_val = ctrl_q;
      wr_val.prescale = pwdata[`CSC_BIT_PRESCALE];
      wr_val.postdiv = pwdata[`CSC_BIT_POSTDIV];
      wr_val.range = pwdata[`CSC_BIT_RANGE];
      wr_val.mult = pwdata[`CSC_MULT_MSB:`CSC_MULT_LSB];
   end

   // only prescale and multiplier move the vco target
   // post-divide sits after the vco and never disturbs lock
   assign vco_change = wr_ctrl && (vco_of(wr_val) != vco_of(ctrl_q));
   assign raise = wr_ctrl && (vco_of(wr_val) > vco_of(ctrl_q));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= CTRL_RST;
      end else if (clk_en) begin
         if (soft_rst) begin
            ctrl_q <= CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_q <= wr_val;
         end
      end
   end

   // lock model: a retarget restarts the settling count in reference periods
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lock_cnt_q <= 16'h0;
      end else if (clk_en) begin
         if (soft_rst || vco_change) begin
            lock_cnt_q <= 16'h0;
         end else if (ref_edge && !vco_locked) begin
            lock_cnt_q <= lock_cnt_q + 16'h1;
         end
      end
   end

   assign vco_locked = lock_cnt_q >= 16'(LOCK_PERIODS);

   // an upward retarget may overshoot; flagged until lock is regained
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         overshoot_q <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst) begin
            overshoot_q <= 1'b0;
         end else if (raise) begin
            overshoot_q <= 1'b1;
         end else if (vco_locked) begin
            overshoot_q <= 1'b0;
         end
      end
   end

   // power-on sequence and clock loss
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= CSC_ST_LOCK_WAIT;
         por_cnt_q <= 16'h0;
      end else if (clk_en) begin
         if (lost_now && state_q != CSC_ST_LOST) begin
            state_q <= CSC_ST_LOST;
         end else begin
            case (state_q)
               CSC_ST_LOCK_WAIT: begin
                  por_cnt_q <= 16'h0;
                  // without the vco there is nothing to wait for
                  if (vco_locked || (!use_vco_q && cap_cnt_q == 2'h3)) begin
                     state_q <= CSC_ST_COUNT;
                  end
               end
               CSC_ST_COUNT: begin
                  if (ref_edge) begin
                     if (por_cnt_q == 16'(POR_PERIODS - 1)) begin
                        state_q <= CSC_ST_RUN;
                     end
                     por_cnt_q <= por_cnt_q + 16'h1;
                  end
               end
               CSC_ST_RUN: begin
                  por_cnt_q <= por_cnt_q;
               end
               CSC_ST_LOST: begin
                  por_cnt_q <= 16'h0;
                  if (ref_edge) begin
                     state_q <= CSC_ST_LOCK_WAIT;
                  end
               end
               default: begin
                  state_q <= CSC_ST_LOCK_WAIT;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sys_reset_n <= 1'b0;
      end else if (clk_en) begin
         sys_reset_n <= (state_q == CSC_ST_RUN) && !lost_now;
      end
   end

   // frequency words in units of the reference; out_of doubles with post-divide
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         freq_q <= '{vco_mult: vco_of(CTRL_RST), system_clock_output_x8: out_of(CTRL_RST)};
      end else if (clk_en) begin
         freq_q.vco_mult <= vco_of(ctrl_q);
         freq_q.system_clock_output_x8 <= out_of(ctrl_q);
      end
   end

   // masked by lock so the flag never reads set in the cycle lock returns
   assign status = '{overshoot: overshoot_q & ~vco_locked, clock_lost: soft_rst,
      por_done: (state_q == CSC_ST_RUN), locked: vco_locked};

   // software polls the lock bit before setting post-divide again
   always_comb begin
      prdata = 32'h0;
      if (psel && !pwrite) begin
         case (paddr)
            `CSC_OFS_CTRL: begin
               prdata[`CSC_BIT_PRESCALE] = ctrl_q.prescale;
               prdata[`CSC_BIT_POSTDIV] = ctrl_q.postdiv;
               prdata[`CSC_BIT_RANGE] = ctrl_q.range;
               prdata[`CSC_MULT_MSB:`CSC_MULT_LSB] = ctrl_q.mult;
            end
            `CSC_OFS_STATUS: begin
               prdata[3:0] = status;
            end
            default: begin
               prdata = 32'h0;
            end
         endcase
      end
   end

endmodule

/* verilog/csc_cfg.svh */
// constants for the clock synthesizer control block
// assumes mclk at 125 MHz and a slow reference clock on a pin
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_CLK_MHZ 125
`define CSC_OFS_CTRL 12'h000
`define CSC_OFS_STATUS 12'h004
`define CSC_BIT_PRESCALE 0
`define CSC_BIT_POSTDIV 1
`define CSC_BIT_RANGE 2
`define CSC_MULT_LSB 8
`define CSC_MULT_MSB 13
`define CSC_RST_PRESCALE 1'h0
`define CSC_RST_POSTDIV 1'h0
`define CSC_RST_RANGE 1'h0
`define CSC_RST_MULT 6'h3f
`define CSC_POR_PERIODS 328
`define CSC_LOCK_PERIODS 16
`define CSC_LOSS_TIME_NS 125000
`define CSC_LOSS_CYCLES ((`CSC_LOSS_TIME_NS * `CSC_CLK_MHZ) / 1000)
`endif

/* verilog/csc_pkg.sv */
// types shared by the clock synthesizer control block
// used together with csc_cfg.svh
package csc_pkg;
   typedef struct packed {
      logic [5:0] mult;
      logic range;
      logic postdiv;
      logic prescale;
   } csc_ctrl_t;

   typedef struct packed {
      logic overshoot;
      logic clock_lost;
      logic por_done;
      logic locked;
   } csc_status_t;

   typedef struct packed {
      logic [10:0] vco_mult;
      logic [13:0] system_clock_output_x8;
   } csc_freq_t;

   typedef enum logic [1:0] {
      CSC_ST_LOCK_WAIT = 2'b00,
      CSC_ST_COUNT = 2'b01,
      CSC_ST_RUN = 2'b11,
      CSC_ST_LOST = 2'b10
   } csc_state_t;
endpackage

/* verification/csc_properties.sv */
// concurrent checks on the csc_synth_ctrl ports
// bound into every csc_synth_ctrl; reference pin assumed free of glitches
`timescale 1ns/1ns
module csc_properties
   import csc_pkg::*;
#(
   parameter int POR_PERIODS = 328,
   parameter int LOCK_PERIODS = 16,
   parameter int LOSS_CYCLES = 15625
) (
   // clock and controls
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and results
   input wire logic ref_clk_pin,
   input wire logic vco_mode_strap,
   input wire csc_freq_t freq_q,
   input wire logic vco_locked,
   input wire logic sys_reset_n
);
   logic [2:0] rs_q;
   logic [15:0] idle_q;
   logic [15:0] por_q;
   wire redge = rs_q[1] & ~rs_q[2];
   // writes while lost are refused, so only running writes are judged
   wire wr = psel & penable & pwrite & clk_en & sys_reset_n & (paddr == 12'h000);
   wire rds = psel & penable & !pwrite & (paddr == 12'h004);
   wire [10:0] tgt = ({5'h0, pwdata[13:8]} + 11'h1) << (pwdata[0] ? 4 : 2);
   wire [1:0] sh = {pwdata[2], pwdata[1]};
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rs_q <= 3'h0;
         idle_q <= 16'h0;
         por_q <= 16'h0;
      end else if (clk_en) begin
         rs_q <= {rs_q[1:0], ref_clk_pin};
         if (redge) idle_q <= 16'h0;
         else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h1;
         if (!vco_locked) por_q <= 16'h0;
         else if (redge) por_q <= por_q + 16'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence same_vco;
      wr && !$past(wr) && tgt == freq_q.vco_mult;
   endsequence
   sequence new_vco;
      wr && !$past(wr) && tgt != freq_q.vco_mult;
   endsequence
   vco_word_a: assert property (wr |-> ##2 freq_q.vco_mult == $past(tgt, 2))
      else $error("vco word does not follow control write");
   out_double_a: assert property (wr |-> ##2 freq_q.system_clock_output_x8 ==
      ({3'h0, freq_q.vco_mult} << $past(sh, 2)))
      else $error("output word wrong for post-divide and range");
   lock_kept_a: assert property (same_vco ##0 vco_locked |=> vco_locked)
      else $error("lock lost on a write that keeps the vco");
   lock_drop_a: assert property (new_vco |=> !vco_locked)
      else $error("lock kept after vco retarget");
   por_count_a: assert property ($rose(sys_reset_n) |->
      por_q >= POR_PERIODS && por_q <= POR_PERIODS + 1)
      else $error("power-on count not kept after lock");
   loss_reset_a: assert property (idle_q == 16'(LOSS_CYCLES + 8) |-> !sys_reset_n &&
      !vco_locked && freq_q == {11'h100, 14'h100})
      else $error("clock loss did not reset the block");
   lock_read_a: assert property (rds |-> prdata[0] == vco_locked)
      else $error("status lock bit differs from lock output");
   over_clear_a: assert property (rds && vco_locked |-> !prdata[3])
      else $error("overshoot flag standing while locked");
endmodule

bind csc_synth_ctrl csc_properties #(.POR_PERIODS(POR_PERIODS), .LOCK_PERIODS(LOCK_PERIODS),
   .LOSS_CYCLES(LOSS_CYCLES)) u_props (.mclk, .arst_n, .clk_en, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_clk_pin, .vco_mode_strap, .freq_q,
   .vco_locked, .sys_reset_n);

/* verification/csc_synth_ctrl_tb_top.sv */
// self-checking bench for csc_synth_ctrl
// drives apb, enable and reference pin; strap held at vco mode
`timescale 1ns/1ns
module csc_synth_ctrl_tb_top;
   import csc_pkg::*;
   localparam int POR = 8;
   localparam int LCK = 2;
   logic mclk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic ref_run = 1, pready, pslverr, er, vco_locked, sys_reset_n;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, c;
   logic [3:0] rc = 4'h0;
   csc_freq_t freq_q;
   int n_fail = 0, n_tests = 0, i, k, nref = 0;
   csc_synth_ctrl #(.POR_PERIODS(POR), .LOCK_PERIODS(LCK), .LOSS_CYCLES(64)) dut (
      .mclk, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ref_clk_pin(rc[3]), .vco_mode_strap(1'b1), .freq_q,
      .vco_locked, .sys_reset_n);
   initial forever #4 mclk = ~mclk;
   // reference at mclk/16, standing still while stopped
   always @(posedge mclk) if (ref_run) rc <= rc + 4'h1;
   always @(posedge rc[3]) nref++;
   task automatic close_out;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int t;
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      for (t = 0; t < 40; t++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (t == 40) begin
         n_fail++;
         close_out;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task automatic wait_hi(input logic run);
      int t;
      for (t = 0; t < 3000; t++) begin
         @(posedge mclk);
         if ((run ? sys_reset_n : vco_locked) === 1'b1) break;
      end
      if (t == 3000) begin
         n_fail++;
         close_out;
      end
      @(posedge mclk);
   endtask
   task automatic wr_freq(input logic [31:0] v);
      logic [10:0] m;
      apb(12'h000, 1, v);
      @(posedge mclk);
      m = ({5'h0, v[13:8]} + 11'h1) << (v[0] ? 4 : 2);
      chk(freq_q.vco_mult, m);
      chk(freq_q.system_clock_output_x8, {3'h0, m} << {v[2], v[1]});
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      arst_n <= 1;
      k = nref;
      apb(12'h000, 0, 0);
      chk(rd, 32'h00003f00);
      chk(freq_q, {11'h100, 14'h100});
      chk(sys_reset_n, 0);
      wait_hi(1);
      chk(nref - k >= LCK + POR && nref - k <= LCK + POR + 2, 1);
      apb(12'h004, 0, 0);
      chk(rd[1:0], 2'h3);
      // sweep keeps away from the forbidden 1:0:47:1 setting and the output rating
      for (i = 0; i < 8; i++) wr_freq({18'h0, 6'(i * 9), 5'h0, 3'(i)});
      // drop, raise, then post-divide after relock so overshoot never reaches the output
      wr_freq(32'h00000a00);
      wait_hi(0);
      wr_freq(32'h00002800);
      apb(12'h004, 0, 0);
      chk(rd[3:0], 4'ha);
      wait_hi(0);
      apb(12'h004, 0, 0);
      chk(rd[3:0], 4'h3);
      wr_freq(32'h00002802);
      chk(vco_locked, 1);
      apb(12'h008, 0, 0);
      chk(er, 1);
      chk(rd, 32'h0);
      chk(pready, 1);
      clk_en <= 0;
      apb(12'h000, 1, 0);
      clk_en <= 1;
      apb(12'h000, 0, 0);
      chk(rd, 32'h00002802);
      ref_run <= 0;
      repeat (90) @(posedge mclk);
      chk(sys_reset_n, 0);
      apb(12'h000, 1, 32'h00000a00);
      apb(12'h000, 0, 0);
      chk(rd, 32'h00003f00);
      apb(12'h004, 0, 0);
      chk(rd[2], 1);
      ref_run <= 1;
      wait_hi(1);
      chk(sys_reset_n, 1);
      close_out;
   end
endmodule
